//--- rtl/fracn_divider_control_regs.svh
// register offsets, field positions, reset values and timing for the divider control
`ifndef FRACN_DIVIDER_CONTROL_REGS_SVH
`define FRACN_DIVIDER_CONTROL_REGS_SVH
`define OFF_ID          6'h00
`define OFF_ENABLE      6'h01
`define OFF_REFDIV      6'h02
`define OFF_INTEGER     6'h03
`define OFF_FRAC        6'h04
`define OFF_MODCFG      6'h06
`define OFF_DIVCFG      6'h08
`define OFF_EXACT       6'h0C
`define OFF_GPOCFG      6'h0F
`define BIT_ENA_PIN     0
`define BIT_ENA_SOFT    1
`define KEEP_LSB        2
`define KEEP_MSB        7
`define BIT_MOD_DSM     11
`define BIT_MOD_INT     7
`define BIT_MOD_ASEED   8
`define SEED_MSB        1
`define SEED_LSB        0
`define BIT_DIV2        19
`define BIT_GPO_EN      7
`define RST_ENABLE      24'h00_0001
`define RST_REFDIV      14'h0001
`define RST_INTEGER     19'h0_0019
`define RST_FRAC        24'h00_0000
`define RST_MODCFG      24'h00_0082
`define RST_DIVCFG      24'h00_0000
`define RST_EXACT       14'h0000
`define RST_GPOCFG      24'h00_0000
`define SEED_PHASE0     24'h00_0000
`define SEED_PHASE1     24'h40_0000
`define SEED_PHASE2     24'h80_0000
`define SEED_PHASE3     24'hC0_0000
`define REFDIV_FULL     15'h4000
`define POR_TIME_US     250
`define CLK_MHZ         125
`define POR_CYCLES      (`POR_TIME_US * `CLK_MHZ)
`endif

//--- rtl/fracn_divider_control_pkg.sv
// types shared by the divider control block
package fracn_divider_control_pkg;
  typedef logic [23:0] word_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    word_t      data;
  } reg_req_s;
  typedef enum logic [0:0] {POR_WAIT, POR_RUN} por_e;
endpackage

//--- rtl/fracn_divider_control.sv
// fractional-N feedback divider, modulator, reference divider and chip control
//
// Overview of operation
// - integer mode keeps the modulator off
// - fractional mode turns the modulator on
// - divide by integer plus fraction over 2^24
// - divider bit 19 adds divide-by-two stage
// - reference divided by 1 to 2^14
// - seed field picks one of four phases
// - autoseed reloads accumulator on new fraction
// - without autoseed accumulator carries over
// - registers reset about 250 us after power
// - enable source is pin or soft bit
// - keep-on bits hold blocks powered when disabled
// - register zero reads the version identifier
// - pin carries general output when enabled
`timescale 1ns/1ps
`include "fracn_divider_control_regs.svh"
module fracn_divider_control
  import fracn_divider_control_pkg::*;
#(
  parameter int          POR_CYCLES        = `POR_CYCLES,
  parameter logic [23:0] VERSION_IDENTIFIER = 24'h00_A5C3
)(
  // clock and reset
  input  wire logic         REF_CLK,
  input  wire logic         RESETN,
  // register access from the serial engine
  input  wire reg_req_s     REG_REQ,
  output logic [23:0]       REG_RDATA,
  output logic              REG_READY,
  // pins and sources from the analog side
  input  wire logic         HARDWARE_ENABLE_PIN,
  input  wire logic         LOCK_DETECT_IN,
  input  wire logic         GENERAL_OUTPUT_IN,
  output logic              LOCK_SERIAL_OUT_PIN_O,
  output logic              LOCK_SERIAL_OUT_PIN_OE,
  // divider and modulator controls
  output logic              PD_PULSE,
  output logic [19:0]       FB_RATIO,
  output logic              DSM_EN,
  output logic              DIV2_EN,
  output logic [13:0]       EXACT_MODULUS,
  // power control
  output logic              CHIP_EN,
  output logic [5:0]        BLOCK_PWR
);
  // power-on wait; register writes are ignored until it ends
  por_e        por_r,       por_nxt;
  logic [31:0] por_cnt_r,   por_cnt_nxt;
  logic        ready;
  always_comb
  begin
    por_nxt     = por_r;
    por_cnt_nxt = por_cnt_r;
    case (por_r)
      POR_WAIT:
      begin
        por_cnt_nxt = por_cnt_r + 32'h0000_0001;
        if (por_cnt_r >= 32'(POR_CYCLES - 1))
          por_nxt = POR_RUN;
      end
      POR_RUN:  por_cnt_nxt = por_cnt_r;
      default:  por_nxt = POR_WAIT;
    endcase
  end
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      por_r     <= POR_WAIT;
      por_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      por_r     <= por_nxt;
      por_cnt_r <= por_cnt_nxt;
    end
  end
  assign ready = (por_r == POR_RUN);

  // register file
  word_t       ena_r,    ena_nxt;
  logic [13:0] refdiv_r, refdiv_nxt;
  logic [18:0] int_r,    int_nxt;
  word_t       frac_r,   frac_nxt;
  word_t       mod_r,    mod_nxt;
  word_t       divcfg_r, divcfg_nxt;
  logic [13:0] exact_r,  exact_nxt;
  word_t       gpo_r,    gpo_nxt;
  word_t       rdata_r,  rdata_nxt;
  logic        frac_wr;
  always_comb
  begin
    ena_nxt    = ena_r;
    refdiv_nxt = refdiv_r;
    int_nxt    = int_r;
    frac_nxt   = frac_r;
    mod_nxt    = mod_r;
    divcfg_nxt = divcfg_r;
    exact_nxt  = exact_r;
    gpo_nxt    = gpo_r;
    rdata_nxt  = rdata_r;
    frac_wr    = 1'b0;
    if (ready && REG_REQ.wr)
    begin
      case (REG_REQ.addr)
        `OFF_ENABLE:  ena_nxt    = REG_REQ.data;
        `OFF_REFDIV:  refdiv_nxt = REG_REQ.data[13:0];
        `OFF_INTEGER: int_nxt    = REG_REQ.data[18:0];
        `OFF_FRAC:
        begin
          frac_nxt = REG_REQ.data;
          frac_wr  = 1'b1;
        end
        `OFF_MODCFG:  mod_nxt    = REG_REQ.data;
        `OFF_DIVCFG:  divcfg_nxt = REG_REQ.data;
        `OFF_EXACT:   exact_nxt  = REG_REQ.data[13:0];
        `OFF_GPOCFG:  gpo_nxt    = REG_REQ.data;
        default:      rdata_nxt  = rdata_r;
      endcase
    end
    if (REG_REQ.rd)
    begin
      case (REG_REQ.addr)
        `OFF_ID:      rdata_nxt = VERSION_IDENTIFIER;
        `OFF_ENABLE:  rdata_nxt = ena_r;
        `OFF_REFDIV:  rdata_nxt = {10'h000, refdiv_r};
        `OFF_INTEGER: rdata_nxt = {5'h00, int_r};
        `OFF_FRAC:    rdata_nxt = frac_r;
        `OFF_MODCFG:  rdata_nxt = mod_r;
        `OFF_DIVCFG:  rdata_nxt = divcfg_r;
        `OFF_EXACT:   rdata_nxt = {10'h000, exact_r};
        `OFF_GPOCFG:  rdata_nxt = gpo_r;
        default:      rdata_nxt = 24'h00_0000;
      endcase
    end
  end

  // registers held at defaults until ready
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN || !ready)
    begin
      ena_r    <= `RST_ENABLE;
      refdiv_r <= `RST_REFDIV;
      int_r    <= `RST_INTEGER;
      frac_r   <= `RST_FRAC;
      mod_r    <= `RST_MODCFG;
      divcfg_r <= `RST_DIVCFG;
      exact_r  <= `RST_EXACT;
      gpo_r    <= `RST_GPOCFG;
      rdata_r  <= 24'h00_0000;
    end
    else
    begin
      ena_r    <= ena_nxt;
      refdiv_r <= refdiv_nxt;
      int_r    <= int_nxt;
      frac_r   <= frac_nxt;
      mod_r    <= mod_nxt;
      divcfg_r <= divcfg_nxt;
      exact_r  <= exact_nxt;
      gpo_r    <= gpo_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // enable pin synchroniser; first stage feeds only the second
  logic cen_s1_r, cen_s2_r;
  // reference divider, modulator and phase accumulator
  logic [14:0] ref_cnt_r,  ref_cnt_nxt;
  logic [14:0] ref_limit;
  logic        pd_r,       pd_nxt;
  word_t       acc_r,      acc_nxt;
  logic [19:0] ratio_r,    ratio_nxt;
  logic        dsm_on;
  logic [24:0] acc_sum;
  word_t       seed_val;
  always_comb
  begin
    ref_limit   = (refdiv_r == 14'h0000) ? `REFDIV_FULL : {1'b0, refdiv_r};
    ref_cnt_nxt = ref_cnt_r + 15'h0001;
    pd_nxt      = 1'b0;
    if (ref_cnt_r >= ref_limit - 15'h0001)
    begin
      ref_cnt_nxt = 15'h0000;
      pd_nxt      = 1'b1;
    end
    // modulator on only in fractional mode
    dsm_on = mod_r[`BIT_MOD_DSM] && !mod_r[`BIT_MOD_INT];
    case (mod_r[`SEED_MSB:`SEED_LSB])
      2'h0:    seed_val = `SEED_PHASE0;
      2'h1:    seed_val = `SEED_PHASE1;
      2'h2:    seed_val = `SEED_PHASE2;
      default: seed_val = `SEED_PHASE3;
    endcase
    acc_sum   = {1'b0, acc_r} + {1'b0, frac_r};
    acc_nxt   = acc_r;
    ratio_nxt = ratio_r;
    if (pd_nxt)
    begin
      // carry adds one count at rate frac/2^24
      if (dsm_on)
      begin
        acc_nxt   = acc_sum[23:0];
        ratio_nxt = {1'b0, int_r} + {19'h0_0000, acc_sum[24]};
      end
      else
        ratio_nxt = {1'b0, int_r};
    end
    // autoseed reload wins over a step
    if (frac_wr && mod_r[`BIT_MOD_ASEED])
      acc_nxt = seed_val;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN || !ready)
    begin
      ref_cnt_r <= 15'h0000;
      pd_r      <= 1'b0;
      acc_r     <= 24'h00_0000;
      ratio_r   <= {1'b0, `RST_INTEGER};
    end
    else
    begin
      ref_cnt_r <= ref_cnt_nxt;
      pd_r      <= pd_nxt;
      acc_r     <= acc_nxt;
      ratio_r   <= ratio_nxt;
    end
  end

  // registered control outputs
  logic        chip_en_r, chip_en_nxt;
  logic [5:0]  pwr_r,     pwr_nxt;
  logic        pin_o_r,   pin_o_nxt;
  logic        dsm_r,     div2_r,    oe_r;
  always_comb
  begin
    chip_en_nxt = ena_r[`BIT_ENA_PIN] ? cen_s2_r : ena_r[`BIT_ENA_SOFT];
    // keep-on bits override a disabled chip
    pwr_nxt     = chip_en_nxt ? 6'h3F : ena_r[`KEEP_MSB:`KEEP_LSB];
    pin_o_nxt   = gpo_r[`BIT_GPO_EN] ? GENERAL_OUTPUT_IN : LOCK_DETECT_IN;
  end
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      cen_s1_r  <= 1'b0;
      cen_s2_r  <= 1'b0;
      chip_en_r <= 1'b0;
      pwr_r     <= 6'h00;
      pin_o_r   <= 1'b0;
      oe_r      <= 1'b0;
      dsm_r     <= 1'b0;
      div2_r    <= 1'b0;
    end
    else
    begin
      cen_s1_r  <= HARDWARE_ENABLE_PIN;
      cen_s2_r  <= cen_s1_r;
      chip_en_r <= chip_en_nxt;
      pwr_r     <= pwr_nxt;
      pin_o_r   <= pin_o_nxt;
      oe_r      <= 1'b1;
      dsm_r     <= dsm_on;
      div2_r    <= divcfg_r[`BIT_DIV2];
    end
  end

  // the pin drives from reset release on; its source follows the output enable bit
  assign LOCK_SERIAL_OUT_PIN_O  = pin_o_r;
  assign LOCK_SERIAL_OUT_PIN_OE = oe_r;
  assign REG_RDATA     = rdata_r;
  assign REG_READY     = (por_r == POR_RUN);
  assign PD_PULSE      = pd_r;
  assign FB_RATIO      = ratio_r;
  assign DSM_EN        = dsm_r;
  assign DIV2_EN       = div2_r;
  assign EXACT_MODULUS = exact_r;
  assign CHIP_EN       = chip_en_r;
  assign BLOCK_PWR     = pwr_r;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence frac_seed_write;
    ready && REG_REQ.wr && (REG_REQ.addr == `OFF_FRAC) && mod_r[`BIT_MOD_ASEED];
  endsequence
  sequence acc_at_seed;
    acc_r == $past(seed_val);
  endsequence

  int_mode_off_a: assert property (ready && !mod_r[`BIT_MOD_DSM] |=> !DSM_EN)
    else $error("modulator on in integer mode");
  frac_mode_on_a: assert property (ready && mod_r[`BIT_MOD_DSM] && !mod_r[`BIT_MOD_INT] |=> DSM_EN)
    else $error("modulator off in fractional mode");
  ratio_carry_a: assert property (pd_r && $past(dsm_on) |-> ratio_r - {1'b0, $past(int_r)} <= 20'h0_0001)
    else $error("feedback ratio off integer plus carry");
  div2_follow_a: assert property (ready ##1 ready |-> DIV2_EN == $past(divcfg_r[`BIT_DIV2]))
    else $error("divide-by-two stage not following bit");
  ref_period_a: assert property (pd_r && refdiv_r == 14'h0005 ##1 refdiv_r == 14'h0005 [*5] |->
    pd_r && !$past(pd_r, 1) && !$past(pd_r, 2) && !$past(pd_r, 3) && !$past(pd_r, 4))
    else $error("reference pulse spacing wrong");
  autoseed_a: assert property (frac_seed_write |=> acc_at_seed)
    else $error("accumulator not reseeded");
  carry_over_a: assert property (ready && !pd_nxt && !(frac_wr && mod_r[`BIT_MOD_ASEED]) |=> $stable(acc_r))
    else $error("accumulator changed without step");
  por_hold_a: assert property ($rose(ready) |-> $past(por_cnt_r) == 32'(POR_CYCLES - 1))
    else $error("power-on delay wrong");
  enable_src_a: assert property (ready && ena_r[`BIT_ENA_PIN] ##1 1 |-> CHIP_EN == $past(cen_s2_r))
    else $error("chip enable not from pin");
  keep_on_a: assert property (!CHIP_EN && $past(ready) |-> BLOCK_PWR == $past(ena_r[`KEEP_MSB:`KEEP_LSB]))
    else $error("keep-on blocks not powered");
  id_read_a: assert property (ready && REG_REQ.rd && REG_REQ.addr == `OFF_ID |=> REG_RDATA == VERSION_IDENTIFIER)
    else $error("identifier read wrong");
  gpo_pin_a: assert property (gpo_r[`BIT_GPO_EN] |=> LOCK_SERIAL_OUT_PIN_O == $past(GENERAL_OUTPUT_IN))
    else $error("pin not carrying general output");
endmodule

//--- dv/fracn_divider_control_tb.sv
// self-checking bench for the divider control block, driven through its register port
`timescale 1ns/1ps
`include "fracn_divider_control_regs.svh"
module fracn_divider_control_tb
  import fracn_divider_control_pkg::*;
;
  localparam logic [23:0] ID = 24'h00_A5C3;
  logic        clk;
  logic        rst_n;
  reg_req_s    req;
  logic [23:0] rdata;
  logic        ready;
  logic        hw_en;
  logic        lock_in;
  logic        gpo_in;
  logic        pin_o;
  logic        pin_oe;
  logic        pd;
  logic [19:0] ratio;
  logic        dsm;
  logic        div2;
  logic [13:0] exact;
  logic        chip_en;
  logic [5:0]  pwr;
  int          bad_count;
  int          compares;
  int          cycles;
  int          p0;
  int          p;
  int          nc;
  int          n;
  word_t       d;
  fracn_divider_control #(.POR_CYCLES(20), .VERSION_IDENTIFIER(ID)) dut (
    .REF_CLK(clk), .RESETN(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .REG_READY(ready),
    .HARDWARE_ENABLE_PIN(hw_en), .LOCK_DETECT_IN(lock_in), .GENERAL_OUTPUT_IN(gpo_in),
    .LOCK_SERIAL_OUT_PIN_O(pin_o), .LOCK_SERIAL_OUT_PIN_OE(pin_oe), .PD_PULSE(pd),
    .FB_RATIO(ratio), .DSM_EN(dsm), .DIV2_EN(div2), .EXACT_MODULUS(exact),
    .CHIP_EN(chip_en), .BLOCK_PWR(pwr));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test();
    $display("totals: %0d mismatches, %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [5:0] a, input word_t v);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.data <= v;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [5:0] a, output word_t v);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    #1 v = rdata;
  endtask
  task settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // gap in clocks between two phase detector pulses
  task pd_gap(output int g);
    int i;
    g = 0;
    i = 0;
    #1;
    while (pd !== 1'b1 && i < 20000)
    begin
      @(posedge clk);
      #1 i++;
    end
    do
    begin
      @(posedge clk);
      #1 g++;
    end while (pd !== 1'b1 && g < 20000);
  endtask
  // a zero fraction first, so leftover carries cannot blur the first index
  task frac_run(input word_t m, input word_t f, output int first, output int cnt);
    int i;
    first = -1;
    cnt = 0;
    wr(`OFF_MODCFG, m);
    wr(`OFF_FRAC, 24'h00_0000);
    // exact quarter needs no rounding; new fraction each run
    wr(`OFF_FRAC, f);
    for (i = 0; i < 12; i++)
    begin
      @(posedge clk);
      #1;
      if (ratio === 20'h0_0015)
      begin
        if (first < 0)
          first = i;
        if (i >= 4)
          cnt++;
      end
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      stop_test();
    end
  end
  initial
  begin
    bad_count = 0;
    compares = 0;
    cycles = 0;
    rst_n = 1'b0;
    req = '0;
    hw_en = 1'b1;
    lock_in = 1'b1;
    gpo_in = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // writes refused during the power-on wait
    wr(`OFF_REFDIV, 24'h00_0005);
    check(ready, 1'b0);
    n = 2;
    while (ready !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(n >= 20 && n <= 23, 1'b1);
    rd(`OFF_REFDIV, d);
    check(d, 24'h00_0001);
    rd(`OFF_INTEGER, d);
    check(d, 24'h00_0019);
    rd(`OFF_MODCFG, d);
    check(d, 24'h00_0082);
    wr(`OFF_ID, 24'h12_3456);
    rd(`OFF_ID, d);
    check(d, ID);
    wr(6'h3F, 24'hFF_FFFF);
    rd(6'h3F, d);
    check(d, 24'h00_0000);
    wr(`OFF_REFDIV, 24'hFF_FFFF);
    rd(`OFF_REFDIV, d);
    check(d, 24'h00_3FFF);
    // back to a pulse every clock, so the ratio follows within a few cycles
    wr(`OFF_REFDIV, 24'h00_0001);
    // mode B step modulus, divisor far below the limit
    wr(`OFF_EXACT, 24'h00_0C00);
    settle();
    check(exact, 14'h0C00);
    // mode bits: only bit 11 set with bit 7 clear runs the modulator
    wr(`OFF_MODCFG, 24'h00_0082);
    settle();
    check(dsm, 1'b0);
    // top of the integer mode range
    wr(`OFF_INTEGER, 24'h07_FFFF);
    settle();
    check(ratio, 20'h7_FFFF);
    // lowest fractional ratio, set before any fractional mode
    wr(`OFF_INTEGER, 24'h00_0014);
    settle();
    check(ratio, 20'h0_0014);
    wr(`OFF_MODCFG, 24'h00_0880);
    settle();
    check(dsm, 1'b0);
    wr(`OFF_MODCFG, 24'h00_0800);
    settle();
    check(dsm, 1'b1);
    wr(`OFF_DIVCFG, 24'h08_0000);
    settle();
    check(div2, 1'b1);
    wr(`OFF_DIVCFG, 24'h00_0000);
    settle();
    check(div2, 1'b0);
    // quarter fraction with a pulse every clock: two carries per eight steps
    frac_run(24'h00_0900, 24'h40_0000, p0, nc);
    check(nc, 2);
    frac_run(24'h00_0902, 24'h40_0000, p, nc);
    check(p, p0 - 2);
    frac_run(24'h00_0901, 24'h40_0000, p, nc);
    check(p, p0 - 1);
    frac_run(24'h00_0903, 24'h40_0000, p, nc);
    check(p, p0 - 3);
    frac_run(24'h00_0900, 24'h00_0000, p, nc);
    check(nc, 0);
    frac_run(24'h00_0802, 24'h40_0000, p, nc);
    check(p, p0);
    // enable source and keep-on bits
    settle();
    check({chip_en, pwr}, 7'h7F);
    @(posedge clk);
    hw_en <= 1'b0;
    settle();
    check({chip_en, pwr}, 7'h00);
    wr(`OFF_ENABLE, 24'h00_00A8);
    settle();
    check({chip_en, pwr}, 7'h2A);
    wr(`OFF_ENABLE, 24'h00_00AA);
    settle();
    check({chip_en, pwr}, 7'h7F);
    // shared pin shows lock detect until the general output is enabled
    check({pin_oe, pin_o}, 2'b11);
    wr(`OFF_GPOCFG, 24'h00_0080);
    settle();
    check(pin_o, 1'b0);
    @(posedge clk);
    gpo_in <= 1'b1;
    lock_in <= 1'b0;
    settle();
    check(pin_o, 1'b1);
    // reference divider period, zero meaning the full count
    wr(`OFF_REFDIV, 24'h00_0005);
    pd_gap(n);
    pd_gap(n);
    check(n, 5);
    wr(`OFF_REFDIV, 24'h00_0000);
    pd_gap(n);
    pd_gap(n);
    check(n, 16384);
    stop_test();
  end
endmodule
